//--- rtl/ovf_pkg.sv
package ovf_pkg;
  // Channel count and register page
  localparam int unsigned NUM_CH        = 6;
  localparam int unsigned NUM_BIAS      = 3;
  localparam logic [7:0]  PAGE_MAIN     = 8'h00;
  // Register offsets
  localparam logic [7:0]  ADDR_CHANNEL1_FAULT_LATCH = 8'h2e;
  localparam logic [7:0]  ADDR_MASK     = 8'h34;
  localparam logic [7:0]  ADDR_POS_OV   = 8'h35;
  localparam logic [7:0]  ADDR_NEG_OV   = 8'h36;
  localparam logic [7:0]  ADDR_BIAS     = 8'h37;
  // Reset values and writable bits
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  MASK_WR_BITS  = 8'hf8;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
  // Mask field positions
  localparam int unsigned MASK_POS_OV   = 7;
  localparam int unsigned MASK_NEG_OV   = 6;
  localparam int unsigned MASK_HI_CUR   = 5;
  localparam int unsigned MASK_LO_CUR   = 4;
  localparam int unsigned MASK_BIAS_OV  = 3;
  // Latch field positions
  localparam int unsigned OV_CH1_BIT    = 7;
  localparam int unsigned BIAS_HI_BIT   = 7;
  localparam int unsigned BIAS_LO_BIT   = 6;
  localparam int unsigned BIAS_OV_BIT   = 5;
  localparam int unsigned CH_VBAT_BIT   = 0;
  // Bias latch vector indexes
  localparam int unsigned BI_HI         = 2;
  localparam int unsigned BI_LO         = 1;
  localparam int unsigned BI_OV         = 0;
endpackage : ovf_pkg

//--- rtl/ovf_latch_if.sv
`timescale 1ns/1ps
interface ovf_latch_if #(
  parameter int unsigned W = 6
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport bank (input set, input clr, output q);
  modport ctrl (output set, output clr, input q);
endinterface : ovf_latch_if

//--- rtl/ovf_latch_bank.sv
`timescale 1ns/1ps
module ovf_latch_bank #(
  parameter int unsigned W = 6
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  ovf_latch_if.bank  lif
);
  logic [W-1:0] latch_q;
  logic [W-1:0] latch_d;

  // Sticky bits, a new fault beats a clear
  always_comb begin
    latch_d = (latch_q & ~lif.clr) | lif.set;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end

  assign lif.q = latch_q;
endmodule : ovf_latch_bank

//--- rtl/ovf_fault_irq.sv
`timescale 1ns/1ps
module ovf_fault_irq #(
  parameter bit SIX_CHANNEL = 1'b1
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_reg_rd,
  input  wire logic                       i_reg_wr,
  input  wire logic [7:0]                 i_reg_page,
  input  wire logic [7:0]                 i_reg_addr,
  input  wire logic [7:0]                 i_reg_wdata,
  input  wire logic [ovf_pkg::NUM_CH-1:0] i_pos_ov_fault,
  input  wire logic [ovf_pkg::NUM_CH-1:0] i_neg_ov_fault,
  input  wire logic [ovf_pkg::NUM_CH-1:0] i_neg_vbat_short,
  input  wire logic                       i_bias_hi_cur,
  input  wire logic                       i_bias_lo_cur,
  input  wire logic                       i_bias_ov,
  output logic      [7:0]                 o_reg_rdata,
  output logic                            o_reg_rvalid,
  output logic                            o_fault_irq
);
  import ovf_pkg::*;

  // Channel presence, ch5/ch6 only on six-channel build
  localparam logic [NUM_CH-1:0] CH_PRESENT = SIX_CHANNEL ? 6'h3f : 6'h0f;

  // Channel vector (index 0 = channel 1) into bits 7 down to 2
  function automatic logic [7:0] pack_ch(input logic [NUM_CH-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      b[OV_CH1_BIT - i] = v[i];
    end
    return b;
  endfunction : pack_ch

  // Which channel latch register an address selects
  function automatic logic [NUM_CH-1:0] ch_hit(input logic [7:0] addr);
    logic [NUM_CH-1:0] h;
    h = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      h[i] = (addr == ADDR_CHANNEL1_FAULT_LATCH + 8'(i));
    end
    return h;
  endfunction : ch_hit

  ovf_latch_if #(.W(NUM_CH))   pos_if ();
  ovf_latch_if #(.W(NUM_CH))   neg_if ();
  ovf_latch_if #(.W(NUM_CH))   vbat_if ();
  ovf_latch_if #(.W(NUM_BIAS)) bias_if ();

  ovf_latch_bank #(.W(NUM_CH)) u_pos_bank (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .lif        (pos_if)
  );
  ovf_latch_bank #(.W(NUM_CH)) u_neg_bank (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .lif        (neg_if)
  );
  ovf_latch_bank #(.W(NUM_CH)) u_vbat_bank (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .lif        (vbat_if)
  );
  ovf_latch_bank #(.W(NUM_BIAS)) u_bias_bank (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .lif        (bias_if)
  );

  logic [7:0]        mask_q;
  logic [7:0]        mask_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic              irq_q;
  logic              irq_d;
  logic              page_ok;
  logic              rd_ok;
  logic [NUM_CH-1:0] ch_rd;

  assign page_ok = (i_reg_page == PAGE_MAIN);
  assign rd_ok   = i_reg_rd & page_ok;
  assign ch_rd   = rd_ok ? ch_hit(i_reg_addr) : '0;

  // Latch set and clear terms
  always_comb begin
    pos_if.set  = i_pos_ov_fault & CH_PRESENT;
    neg_if.set  = i_neg_ov_fault & CH_PRESENT;
    vbat_if.set = i_neg_vbat_short & CH_PRESENT;
    pos_if.clr  = ch_rd;
    neg_if.clr  = ch_rd;
    vbat_if.clr = {NUM_CH{rd_ok && (i_reg_addr == ADDR_NEG_OV)}};
    bias_if.set = {i_bias_hi_cur, i_bias_lo_cur, i_bias_ov};
    bias_if.clr = {NUM_BIAS{rd_ok && (i_reg_addr == ADDR_BIAS)}};
  end

  // Mask register write
  always_comb begin
    mask_d = mask_q;
    if (i_reg_wr && page_ok && (i_reg_addr == ADDR_MASK)) begin
      mask_d = i_reg_wdata & MASK_WR_BITS;
    end
  end

  // Read data mux
  always_comb begin
    rvalid_d = i_reg_rd;
    rdata_d  = 8'h00;
    if (!rd_ok) begin
      rdata_d = 8'h00;
    end else if (i_reg_addr == ADDR_MASK) begin
      rdata_d = mask_q & MASK_WR_BITS;
    end else if (i_reg_addr == ADDR_POS_OV) begin
      rdata_d = pack_ch(pos_if.q & CH_PRESENT);
    end else if (i_reg_addr == ADDR_NEG_OV) begin
      rdata_d = pack_ch(neg_if.q & CH_PRESENT);
    end else if (i_reg_addr == ADDR_BIAS) begin
      rdata_d[BIAS_HI_BIT] = bias_if.q[BI_HI];
      rdata_d[BIAS_LO_BIT] = bias_if.q[BI_LO];
      rdata_d[BIAS_OV_BIT] = bias_if.q[BI_OV];
    end else if (|ch_rd) begin
      rdata_d[CH_VBAT_BIT] = |(vbat_if.q & ch_rd);
    end
  end

  // Interrupt from unmasked latched faults
  always_comb begin
    irq_d = ((|pos_if.q) & ~mask_q[MASK_POS_OV])
          | ((|neg_if.q) & ~mask_q[MASK_NEG_OV])
          | (bias_if.q[BI_HI] & ~mask_q[MASK_HI_CUR])
          | (bias_if.q[BI_LO] & ~mask_q[MASK_LO_CUR])
          | (bias_if.q[BI_OV] & ~mask_q[MASK_BIAS_OV])
          | (|vbat_if.q);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mask_q   <= MASK_RESET;
      rdata_q  <= RDATA_RESET;
      rvalid_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q    <= irq_d;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_fault_irq  = irq_q;
endmodule : ovf_fault_irq

//--- verification/ovf_fault_irq_sva.sv
`timescale 1ns/1ps
module ovf_fault_irq_sva #(parameter bit SIX_CHANNEL = 1'b1) (
  input wire logic                       i_core_clk, i_rst, i_reg_rd, i_reg_wr,
  input wire logic [7:0]                 i_reg_page, i_reg_addr, i_reg_wdata,
  input wire logic [ovf_pkg::NUM_CH-1:0] i_pos_ov_fault, i_neg_ov_fault, i_neg_vbat_short,
  input wire logic                       i_bias_hi_cur, i_bias_lo_cur, i_bias_ov,
  input wire logic [7:0]                 o_reg_rdata,
  input wire logic                       o_reg_rvalid, o_fault_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence rd_at(logic [7:0] a);
    i_reg_rd && i_reg_page == 8'h00 && i_reg_addr == a;
  endsequence
  sequence wr_mask;
    i_reg_wr && i_reg_page == 8'h00 && i_reg_addr == 8'h34;
  endsequence
  mask_write_a: assert property (wr_mask ##1 rd_at(8'h34) |=>
    o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hf8)) else $error("mask readback");
  mask_rsvd_a: assert property (rd_at(8'h34) |=> o_reg_rdata[2:0] == 3'h0)
    else $error("mask reserved bits");
  latch_rsvd_a: assert property (rd_at(8'h35) or rd_at(8'h36) |=>
    o_reg_rdata[1:0] == 2'h0) else $error("latch reserved bits");
  pos_set_a: assert property (i_pos_ov_fault[0] ##1 rd_at(8'h35) |=> o_reg_rdata[7])
    else $error("positive latch not set");
  pos_clear_a: assert property (rd_at(8'h2e) ##0 !i_pos_ov_fault[0] ##1
    rd_at(8'h35) |=> !o_reg_rdata[7]) else $error("positive latch not cleared");
  neg_clear_a: assert property (rd_at(8'h33) ##0 !i_neg_ov_fault[5] ##1
    rd_at(8'h36) |=> !o_reg_rdata[2]) else $error("negative latch not cleared");
  neg_six_a: assert property (SIX_CHANNEL && i_neg_ov_fault[5] ##1
    rd_at(8'h36) |=> o_reg_rdata[2]) else $error("channel six latch not set");
  vbat_clear_a: assert property (rd_at(8'h36) ##0 !i_neg_vbat_short[0] ##1
    rd_at(8'h2e) |=> !o_reg_rdata[0]) else $error("short latch not cleared");
  bias_set_a: assert property (i_bias_hi_cur ##1 rd_at(8'h37) |=> o_reg_rdata[7])
    else $error("bias latch not set");
endmodule : ovf_fault_irq_sva
bind ovf_fault_irq ovf_fault_irq_sva #(.SIX_CHANNEL(SIX_CHANNEL)) u_sva (.*);

//--- verification/ovf_host_model.sv
`timescale 1ns/1ps
module ovf_host_model (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid,
  output logic            o_reg_rd = 1'b0,
  output logic            o_reg_wr = 1'b0,
  output logic [7:0]      o_reg_addr = 8'h00,
  output logic [7:0]      o_reg_wdata = 8'h00
);
  // Answer is read 1ns after the edge that samples the request
  task automatic rd(input logic [7:0] a, input bit hold, output logic [7:0] d);
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_core_clk);
    #1;
    if (!hold) o_reg_rd = 1'b0;
    d = i_reg_rvalid ? i_reg_rdata : 8'hxx;
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
  endtask : wr
endmodule : ovf_host_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import ovf_pkg::*;
  logic              clk = 0, rst = 1, rd, wr, hb = 0, lb = 0, ob = 0, irq, rv;
  logic [7:0]        ad, wd, rdat;
  logic [NUM_CH-1:0] pf = '0, nf = '0, vf = '0;
  int                mismatches = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  ovf_host_model host (.i_core_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
    .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(ad), .o_reg_wdata(wd));
  ovf_fault_irq #(.SIX_CHANNEL(1'b1)) dut (.i_core_clk(clk), .i_rst(rst), .i_reg_rd(rd),
    .i_reg_wr(wr), .i_reg_page(8'h00), .i_reg_addr(ad), .i_reg_wdata(wd),
    .i_pos_ov_fault(pf), .i_neg_ov_fault(nf), .i_neg_vbat_short(vf), .i_bias_hi_cur(hb),
    .i_bias_lo_cur(lb), .i_bias_ov(ob), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
    .o_fault_irq(irq));
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, exp, input bit hold = 0);
    logic [7:0] v;
    host.rd(a, hold, v);
    check(v, exp);
  endtask : rchk
  task automatic irq_chk(input logic [7:0] m, input logic exp);
    host.wr(ADDR_MASK, m);
    @(posedge clk);
    #1 check({7'h0, irq}, {7'h0, exp});
  endtask : irq_chk
  task automatic mask_case(input logic [7:0] m, ra, rexp);
    irq_chk(m, 1'b0);
    irq_chk(~m & 8'hf8, 1'b1);
    rchk(ra, rexp);
    irq_chk(8'h00, 1'b0);
  endtask : mask_case
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    rchk(ADDR_MASK, 8'h00, 1);
    rchk(ADDR_POS_OV, 8'h00, 1);
    rchk(ADDR_NEG_OV, 8'h00);
    host.wr(ADDR_MASK, 8'hff);
    rchk(ADDR_MASK, 8'hf8);
    {pf, nf, hb, lb, ob} = '1;
    @(posedge clk);
    #1;
    rchk(ADDR_POS_OV, 8'hfc, 1);
    rchk(ADDR_NEG_OV, 8'hfc, 1);
    rchk(ADDR_BIAS, 8'he0, 1);
    {pf, nf, hb, lb, ob} = '0;
    rchk(ADDR_BIAS, 8'he0, 1);
    rchk(ADDR_BIAS, 8'h00);
    host.wr(ADDR_POS_OV, 8'h00);
    rchk(ADDR_POS_OV, 8'hfc);
    rchk(8'h38, 8'h00);
    check({7'h0, irq}, 8'h00);
    host.wr(ADDR_MASK, 8'h00);
    @(posedge clk);
    #1 check({7'h0, irq}, 8'h01);
    rchk(ADDR_CHANNEL1_FAULT_LATCH, 8'h00, 1);
    rchk(ADDR_POS_OV, 8'h7c, 1);
    rchk(ADDR_NEG_OV, 8'h7c, 1);
    for (int i = 1; i < 6; i++) rchk(ADDR_CHANNEL1_FAULT_LATCH + 8'(i), 8'h00, 1);
    rchk(ADDR_NEG_OV, 8'h00, 1);
    rchk(ADDR_POS_OV, 8'h00);
    @(posedge clk);
    #1 check({7'h0, irq}, 8'h00);
    vf[0] = 1'b1;
    @(posedge clk);
    #1 vf[0] = 1'b0;
    rchk(ADDR_CHANNEL1_FAULT_LATCH, 8'h01, 1);
    rchk(ADDR_NEG_OV, 8'h00, 1);
    rchk(ADDR_CHANNEL1_FAULT_LATCH, 8'h00);
    hb = 1'b1;
    @(posedge clk);
    #1 hb = 1'b0;
    mask_case(8'h20, ADDR_BIAS, 8'h80);
    lb = 1'b1;
    @(posedge clk);
    #1 lb = 1'b0;
    mask_case(8'h10, ADDR_BIAS, 8'h40);
    ob = 1'b1;
    @(posedge clk);
    #1 ob = 1'b0;
    mask_case(8'h08, ADDR_BIAS, 8'h20);
    nf[1] = 1'b1;
    @(posedge clk);
    #1 nf[1] = 1'b0;
    mask_case(8'h40, ADDR_CHANNEL1_FAULT_LATCH + 8'h01, 8'h00);
    pf[2] = 1'b1;
    @(posedge clk);
    #1 pf[2] = 1'b0;
    mask_case(8'h80, ADDR_CHANNEL1_FAULT_LATCH + 8'h02, 8'h00);
    rchk(ADDR_POS_OV, 8'h00);
    finish_test();
  end
endmodule : tb
